// ===== shared/frame_format_regs.vh
// bit layout, reset value and prescale constants of the frame format register
`ifndef FRAME_FORMAT_REGS_VH
`define FRAME_FORMAT_REGS_VH
`define FFC_RESET        8'h00
`define FFC_MODE_BIT     7
`define FFC_CHR_BIT      6
`define FFC_PE_BIT       5
`define FFC_ODD_BIT      4
`define FFC_STOP_BIT     3
`define FFC_MP_BIT       2
`define FFC_CKS_HI_BIT   1
`define FFC_CKS_LO_BIT   0
`define PRESC_DIV1       2'h0
`define PRESC_DIV4       2'h1
`define PRESC_DIV16      2'h2
`define PRESC_DIV64      2'h3
`define PRESC_CNT_W      6
`define PRESC_MAX4       6'h03
`define PRESC_MAX16      6'h0F
`define PRESC_MAX64      6'h3F
`endif

// ===== core/baud_prescaler.v
// peripheral clock prescaler producing a one-cycle baud clock enable
`timescale 1ns/1ps
`include "frame_format_regs.vh"
module baud_prescaler (
    input  wire       sys_clk_i,
    input  wire       nrst_i,
    input  wire [1:0] sel_i,
    output reg        tick_o
);
    reg  [`PRESC_CNT_W-1:0] cnt_q;
    reg  [`PRESC_CNT_W-1:0] max_w;

    always @* begin
        case (sel_i)
            `PRESC_DIV4:  max_w = `PRESC_MAX4;
            `PRESC_DIV16: max_w = `PRESC_MAX16;
            `PRESC_DIV64: max_w = `PRESC_MAX64;
            default:      max_w = {`PRESC_CNT_W{1'b0}};
        endcase
    end

    always @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            cnt_q  <= {`PRESC_CNT_W{1'b0}};
            tick_o <= 1'b0;
        end else if (cnt_q >= max_w) begin
            cnt_q  <= {`PRESC_CNT_W{1'b0}};
            tick_o <= 1'b1;
        end else begin
            cnt_q  <= cnt_q + {{(`PRESC_CNT_W-1){1'b0}}, 1'b1};
            tick_o <= 1'b0;
        end
    end
endmodule

// ===== core/frame_format_control.v
// frame format register of the serial unit with decoded format controls
// What this block does
// - register reads anytime, writes outside standby only; resets to 0x00 on every reset kind.
// - bit 7 chooses asynchronous (0) or clock-synchronous (1) mode.
// - async bit 6 selects 8 or 7 data bits; sync always 8.
// - with 7-bit characters, transmit holding bit 7 is never sent.
// - async parity enable adds and checks parity; sync never does.
// - parity sense 0 gives even total of ones including parity.
// - parity sense 1 gives odd total of ones including parity.
// - parity sense matters only with parity enabled in async mode.
// - async transmit sends one or two high stop bits; sync none.
// - receiver checks only the first stop bit regardless of setting.
// - multiprocessor format overrides parity settings, async mode only.
// - prescale codes divide peripheral clock by 1, 4, 16 or 64.
`timescale 1ns/1ps
`include "frame_format_regs.vh"
module frame_format_control (
    input  wire       sys_clk_i,
    input  wire       nrst_i,
    input  wire       standby_i,
    input  wire       wr_en_i,
    input  wire [7:0] wr_data_i,
    input  wire [7:0] tx_holding_i,
    input  wire [7:0] rx_char_i,
    input  wire       rx_parity_i,
    output reg  [7:0] rd_data_o,
    output reg        sync_mode_o,
    output reg        char7_o,
    output reg        parity_on_o,
    output reg        parity_odd_o,
    output reg        stop2_o,
    output reg        multiproc_o,
    output reg  [7:0] tx_char_o,
    output reg        tx_parity_o,
    output reg        rx_parity_err_o,
    output reg        baud_tick_o
);
    reg  [7:0] frame_format_control_q;
    reg  [7:0] frame_format_control_d;
    wire       async_w;
    wire       chr_w;
    wire       par_on_w;
    wire       odd_w;
    wire [7:0] tx_char_w;
    wire       tick_w;

    always @* begin
        frame_format_control_d = frame_format_control_q;
        if (wr_en_i) begin
            frame_format_control_d = wr_data_i;
        end
    end

    // standby and module standby clear the register like a reset
    always @(posedge sys_clk_i) begin
        if (!nrst_i || standby_i) begin
            frame_format_control_q <= `FFC_RESET;
        end else begin
            frame_format_control_q <= frame_format_control_d;
        end
    end

    assign async_w   = ~frame_format_control_q[`FFC_MODE_BIT];
    assign chr_w     = async_w & frame_format_control_q[`FFC_CHR_BIT];
    // multiprocessor format suppresses parity
    assign par_on_w  = async_w & frame_format_control_q[`FFC_PE_BIT]
                       & ~frame_format_control_q[`FFC_MP_BIT];
    assign odd_w     = par_on_w & frame_format_control_q[`FFC_ODD_BIT];
    assign tx_char_w = chr_w ? {1'b0, tx_holding_i[6:0]} : tx_holding_i;

    baud_prescaler u_presc (
        .sys_clk_i (sys_clk_i),
        .nrst_i    (nrst_i),
        .sel_i     (frame_format_control_q[`FFC_CKS_HI_BIT:`FFC_CKS_LO_BIT]),
        .tick_o    (tick_w)
    );

    always @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            rd_data_o       <= `FFC_RESET;
            sync_mode_o     <= 1'b0;
            char7_o         <= 1'b0;
            parity_on_o     <= 1'b0;
            parity_odd_o    <= 1'b0;
            stop2_o         <= 1'b0;
            multiproc_o     <= 1'b0;
            tx_char_o       <= 8'h00;
            tx_parity_o     <= 1'b0;
            rx_parity_err_o <= 1'b0;
            baud_tick_o     <= 1'b0;
        end else begin
            rd_data_o       <= frame_format_control_q;
            sync_mode_o     <= ~async_w;
            char7_o         <= chr_w;
            parity_on_o     <= par_on_w;
            parity_odd_o    <= odd_w;
            // stop length shapes transmit framing only; the receiver checks just the first stop bit
            stop2_o         <= async_w & frame_format_control_q[`FFC_STOP_BIT];
            multiproc_o     <= async_w & frame_format_control_q[`FFC_MP_BIT];
            tx_char_o       <= tx_char_w;
            // parity bit making total ones even (sense 0) or odd (sense 1)
            tx_parity_o     <= par_on_w & ((^tx_char_w) ^ odd_w);
            rx_parity_err_o <= par_on_w & ((^(chr_w ? {1'b0, rx_char_i[6:0]} : rx_char_i))
                               ^ rx_parity_i ^ odd_w);
            baud_tick_o     <= tick_w;
        end
    end
endmodule

// ===== testbench/ffc_monitor.sv
// concurrent checks on the frame format register ports
`timescale 1ns/1ps
module ffc_monitor (
    input logic       sys_clk_i,
    input logic       nrst_i,
    input logic       standby_i,
    input logic       wr_en_i,
    input logic [7:0] wr_data_i,
    input logic [7:0] rd_data_o,
    input logic       sync_mode_o,
    input logic       char7_o,
    input logic       parity_on_o,
    input logic       parity_odd_o,
    input logic [7:0] tx_char_o,
    input logic       baud_tick_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    wire asy = !rd_data_o[7];
    a_mode_sel: assert property (sync_mode_o == rd_data_o[7]) else $error("mode");
    a_char_len: assert property (char7_o == (asy & rd_data_o[6])) else $error("length");
    a_parity_gate: assert property (parity_on_o == (asy & rd_data_o[5] & !rd_data_o[2]))
        else $error("parity");
    a_parity_sense: assert property (parity_odd_o == (parity_on_o & rd_data_o[4]))
        else $error("sense");
    a_write_read: assert property (wr_en_i && !standby_i ##1 !standby_i |-> ##1 rd_data_o == $past(wr_data_i, 2))
        else $error("readback");
    a_standby_clear: assert property (standby_i |-> ##2 rd_data_o == 8'h00) else $error("standby");
    a_msb_trim: assert property (char7_o && $past(char7_o) |-> !tx_char_o[7]) else $error("msb");
    a_tick_every: assert property ((rd_data_o[1:0] == 2'h0)[*3] |-> baud_tick_o) else $error("tick");
endmodule
bind frame_format_control ffc_monitor mon (.*);

// ===== testbench/remote_chip.sv
// remote serial chip returning each character with its parity bit
`timescale 1ns/1ps
module remote_chip (
    input  logic       sys_clk_i,
    input  logic [7:0] byte_i,
    input  logic       char7_i,
    input  logic       odd_i,
    input  logic       bad_i,
    output logic [7:0] rx_char_o = 8'h00,
    output logic       rx_parity_o = 1'b0
);
    wire [7:0] ch = char7_i ? {1'b0, byte_i[6:0]} : byte_i;
    always @(posedge sys_clk_i) begin
        rx_char_o <= #1 ch;
        rx_parity_o <= #1 ^ch ^ odd_i ^ bad_i;
    end
endmodule

// ===== testbench/tb.sv
// self-checking bench of the frame format register
`timescale 1ns/1ps
module tb;
    logic sys_clk_i = 0, nrst_i = 0, standby_i = 0, wr_en_i = 0, bad = 0, rx_parity_i, baud_tick_o;
    logic sync_mode_o, char7_o, parity_on_o, parity_odd_o, stop2_o, multiproc_o, tx_parity_o, rx_parity_err_o;
    logic [7:0] wr_data_i = 8'h00, tx_holding_i = 8'h00, rx_char_i, rd_data_o, tx_char_o, c;
    logic [15:0] lfsr = 16'hC103;
    int fail_count = 0, n_tests = 0, ticks;
    wire [23:0] outs = {rd_data_o, sync_mode_o, char7_o, parity_on_o, parity_odd_o, stop2_o, multiproc_o,
                        tx_char_o, tx_parity_o, rx_parity_err_o};
    frame_format_control DUT (.*);
    remote_chip far (.sys_clk_i, .byte_i(tx_holding_i), .char7_i(char7_o), .odd_i(parity_odd_o), .bad_i(bad),
                     .rx_char_o(rx_char_i), .rx_parity_o(rx_parity_i));
    function automatic logic [15:0] nxt(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [23:0] model(logic [7:0] f, h, logic b);
        logic a, p, s;
        logic [7:0] t;
        a = !f[7];
        s = a & f[6];
        p = a & f[5] & !f[2];
        t = s ? {1'b0, h[6:0]} : h;
        return {f, f[7], s, p, p & f[4], a & f[3], a & f[2], t, p & (^t ^ f[4]), p & b};
    endfunction
    task automatic tick(int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic wr(logic [7:0] d);
        wr_data_i = d;
        wr_en_i = 1;
        tick(1);
        wr_en_i = 0;
    endtask
    task automatic cmp(logic [23:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t mismatch got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        $display("%0d checks, %0d mismatches", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial forever #10 sys_clk_i = ~sys_clk_i;
    initial begin
        #100000 fail_count++;
        stop_test;
    end
    initial begin
        tick(10);
        nrst_i = 1;
        tick(2);
        cmp(outs, 24'h0);
        $display("reset test done");
        for (int i = 0; i < 60; i++) begin
            lfsr = nxt(lfsr);
            c = i < 4 ? 8'(32'h707CFF28 >> 8 * i) : lfsr[7:0];
            tx_holding_i = lfsr[15:8];
            bad = lfsr[9];
            wr(c);
            tick(4);
            cmp(outs, model(c, tx_holding_i, bad));
        end
        $display("format test done");
        standby_i = 1;
        wr_en_i = 1;
        tick(1);
        {standby_i, wr_en_i} = 2'h0;
        tick(4);
        cmp(outs, model(8'h00, tx_holding_i, bad));
        $display("standby test done");
        for (int k = 0; k < 4; k++) begin
            wr(8'(k));
            tick(8);
            ticks = 0;
            repeat (128) begin
                tick(1);
                ticks += baud_tick_o;
            end
            cmp(24'(ticks), 24'(128 >> 2 * k));
        end
        $display("prescale test done");
        stop_test;
    end
endmodule
